/* File: core/ubc_defines.svh */
// Register offsets, field positions, reset values and timing for the bus control register bank
`ifndef UBC_DEFINES_SVH
`define UBC_DEFINES_SVH
// Printed offsets are not all multiples of four: they are indices, byte address is four times
`define UBC_IDX_BUS_STATUS_CONTROL 8'h1A
`define UBC_IDX_ENDPOINT_REQUEST_STATUS 8'h1B
`define UBC_IDX_SYSTEM_CLOCK_CONTROL 8'h1C
`define UBC_IDX_TABLE_HIGH_POINTER 8'h1F
`define UBC_IDX_IRQ_STATUS 8'h20
`define UBC_IDX_IRQ_MASK 8'h21
// Bus status/control fields
`define UBC_BSC_BUS_RESET 2
`define UBC_BSC_DATA_IN 4
`define UBC_BSC_CLOCK_IN 5
`define UBC_BSC_DATA_OUT 6
`define UBC_BSC_CLOCK_OUT 7
// Endpoint request status fields
`define UBC_EPR_LEGACY_SEL 4
`define UBC_EPR_USB_SEL 5
`define UBC_EPR_USB_IND 7
// System clock control fields
`define UBC_SCC_USB_CLK 3
`define UBC_SCC_DEEP_SUSP 4
`define UBC_SCC_LEGACY_IND 5
`define UBC_SCC_OSC_SEL 6
`define UBC_SCC_WRITABLE 8'h78
// Interrupt status fields: endpoints 0..2, bus reset
`define UBC_IRQ_BUS_RESET 3
// Reset values
`define UBC_RST_DRIVE 2'h3
`define UBC_RST_BYTE 8'h00
// Bench clock figure, kept for reference
`define UBC_CLK_PERIOD_NS 10
`endif

/* File: core/ubc_pkg.sv */
// Types for the bus control register bank
package ubc_pkg;
    typedef enum logic [1:0] {UBC_RESP_OKAY = 2'h0, UBC_RESP_SLVERR = 2'h2} ubc_resp_e;
    typedef logic [7:0] ubc_byte_t;
endpackage : ubc_pkg

/* File: core/ubc_regs.sv */
// Bus interface control registers of a keyboard controller, AXI4-Lite slave
// Function
// RL1: Bus status bit 4 reads the live data pin level.
// RL2: Bus status bit 5 reads the live clock pin level.
// RL3: Bus status bit 6 is write-only, resets 1, drives data pin in legacy mode.
// RL4: Bus status bit 7 is write-only, resets 1, drives clock pin in legacy mode.
// RL5: Engine sets endpoint flags 0..2 when those endpoints are accessed.
// RL6: A set endpoint flag raises the interrupt if enabled and stack not full.
// RL7: Firmware writes 0 to clear a serviced flag; it stays set until then.
// RL8: Endpoint register bit 4 selects legacy function, resets 0.
// RL9: Endpoint register bit 5 selects USB function, resets 0.
// RL10: Endpoint register bit 7 is a firmware USB indicator, reset 0.
// RL11: Clock control bit 5 is a firmware legacy indicator, reset 0.
// RL12: Firmware writes 0 to clock control bits 2..0 and 7.
// RL13: Clock control bit 3 gates the USB clock, reset 0.
// RL14: Firmware keeps clock control bit 4 low while running, high in halt.
// RL15: Clock control bit 6 gives oscillator frequency, 1 for 6MHz, reset 0.
// RL16: Table pointer bits 3..0 read program address bits 11..8 of table read.
// RL17: Table pointer is enabled by a fixed option, disabled by default.
// RL18: Engine sets bus status bit 2 on USB bus reset and raises interrupt.
// RL19: Writing 0 clears an endpoint flag; a same-cycle set wins.
`timescale 1ns/1ns
`include "ubc_defines.svh"
module ubc_regs #(
    parameter bit TABLE_POINTER_ENABLE = 1'b0
) (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic LEGACY_DATA_IN,
    input wire logic LEGACY_CLOCK_IN,
    output logic LEGACY_DATA_OUT,
    output logic LEGACY_DATA_OE,
    output logic LEGACY_CLOCK_OUT,
    output logic LEGACY_CLOCK_OE,
    input wire logic [2:0] ENDPOINT_ACCESS,
    input wire logic USB_BUS_RESET,
    input wire logic STACK_FULL,
    input wire logic [3:0] TABLE_PAGE_BITS,
    output logic USB_CLOCK_GATE,
    output logic DEEP_SUSPEND_POWER_CUT,
    output logic OSCILLATOR_FREQUENCY_SELECT,
    output logic LEGACY_FUNCTION_SELECT,
    output logic USB_FUNCTION_SELECT,
    output logic IRQ
);
    // Byte address of a register index
    function automatic logic [7:0] reg_addr(input logic [7:0] idx);
        reg_addr = {idx[5:0], 2'h0};
    endfunction : reg_addr

    logic [1:0] data_sync_reg;
    logic [1:0] clock_sync_reg;
    logic [1:0] drive_reg;
    logic [2:0] ep_flag_reg;
    logic [2:0] ep_flag_next;
    logic bus_reset_reg;
    logic legacy_sel_reg;
    logic usb_sel_reg;
    logic usb_ind_reg;
    ubc_pkg::ubc_byte_t scc_reg;
    logic [3:0] page_reg;
    logic [3:0] irq_stat_reg;
    logic [3:0] irq_stat_next;
    logic [3:0] irq_mask_reg;
    logic [3:0] event_set;
    logic [7:0] aw_addr_reg;
    logic aw_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic w_held_reg;
    logic wr_fire;
    logic wr_ok;
    logic [7:0] wr_byte;
    logic [7:0] rd_byte;
    logic rd_ok;

    // Pin levels arrive from outside the clock domain: two stages first
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
        begin
            data_sync_reg <= 2'h0;
            clock_sync_reg <= 2'h0;
        end
        else
        begin
            data_sync_reg <= {data_sync_reg[0], LEGACY_DATA_IN};
            clock_sync_reg <= {clock_sync_reg[0], LEGACY_CLOCK_IN};
        end
    end

    // Write channel capture; address and data may come in either order
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end
        else
        begin
            if (S_AXI_AWVALID && S_AXI_AWREADY)
            begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= S_AXI_AWADDR;
            end
            else if (wr_fire)
            begin
                aw_held_reg <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY)
            begin
                w_held_reg <= 1'b1;
                w_data_reg <= S_AXI_WDATA;
                w_strb_reg <= S_AXI_WSTRB;
            end
            else if (wr_fire)
            begin
                w_held_reg <= 1'b0;
            end
        end
    end

    // Register write fires once both halves are held and no response is pending
    assign wr_fire = aw_held_reg && w_held_reg && !S_AXI_BVALID;
    assign wr_byte = w_data_reg[7:0];
    assign wr_ok = (aw_addr_reg == reg_addr(`UBC_IDX_BUS_STATUS_CONTROL))
        || (aw_addr_reg == reg_addr(`UBC_IDX_ENDPOINT_REQUEST_STATUS))
        || (aw_addr_reg == reg_addr(`UBC_IDX_SYSTEM_CLOCK_CONTROL))
        || (aw_addr_reg == reg_addr(`UBC_IDX_TABLE_HIGH_POINTER))
        || (aw_addr_reg == reg_addr(`UBC_IDX_IRQ_STATUS))
        || (aw_addr_reg == reg_addr(`UBC_IDX_IRQ_MASK));

    function automatic logic wr_hit(input logic [7:0] idx);
        wr_hit = wr_fire && w_strb_reg[0] && (aw_addr_reg == reg_addr(idx));
    endfunction : wr_hit

    // Write ready and response
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
        begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= 2'h0;
        end
        else
        begin
            S_AXI_AWREADY <= !aw_held_reg && !(S_AXI_AWVALID && S_AXI_AWREADY) && !S_AXI_BVALID;
            S_AXI_WREADY <= !w_held_reg && !(S_AXI_WVALID && S_AXI_WREADY) && !S_AXI_BVALID;
            if (wr_fire)
            begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= wr_ok ? ubc_pkg::UBC_RESP_OKAY : ubc_pkg::UBC_RESP_SLVERR;
            end
            else if (S_AXI_BREADY)
            begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // Pin drive values, write-only, idle high
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
            drive_reg <= `UBC_RST_DRIVE; // see RL3 see RL4
        else if (wr_hit(`UBC_IDX_BUS_STATUS_CONTROL))
            drive_reg <= {wr_byte[`UBC_BSC_CLOCK_OUT], wr_byte[`UBC_BSC_DATA_OUT]}; // see RL3 see RL4
    end

    // Endpoint flags: engine set beats a firmware clear in the same cycle
    always_comb
    begin
        ep_flag_next = ep_flag_reg;
        if (wr_hit(`UBC_IDX_ENDPOINT_REQUEST_STATUS))
            ep_flag_next = ep_flag_reg & wr_byte[2:0]; // see RL7 see RL19
        ep_flag_next = ep_flag_next | ENDPOINT_ACCESS; // see RL5 see RL19
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
            ep_flag_reg <= 3'h0;
        else
            ep_flag_reg <= ep_flag_next;
    end

    // Function selects and USB indicator, firmware owned
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
        begin
            legacy_sel_reg <= 1'b0;
            usb_sel_reg <= 1'b0;
            usb_ind_reg <= 1'b0;
        end
        else if (wr_hit(`UBC_IDX_ENDPOINT_REQUEST_STATUS))
        begin
            legacy_sel_reg <= wr_byte[`UBC_EPR_LEGACY_SEL]; // see RL8
            usb_sel_reg <= wr_byte[`UBC_EPR_USB_SEL]; // see RL9
            usb_ind_reg <= wr_byte[`UBC_EPR_USB_IND]; // see RL10
        end
    end

    // Bus reset indication follows the engine; firmware may clear it
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
            bus_reset_reg <= 1'b0;
        else if (USB_BUS_RESET)
            bus_reset_reg <= 1'b1; // see RL18
        else if (wr_hit(`UBC_IDX_BUS_STATUS_CONTROL) && !wr_byte[`UBC_BSC_BUS_RESET])
            bus_reset_reg <= 1'b0;
    end

    // Clock control; undefined bits held at zero whatever firmware writes
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
            scc_reg <= `UBC_RST_BYTE; // see RL11 see RL13 see RL15
        else if (wr_hit(`UBC_IDX_SYSTEM_CLOCK_CONTROL))
            scc_reg <= wr_byte & `UBC_SCC_WRITABLE; // see RL12 see RL14
    end

    // Table page bits only latch when the option enables the pointer
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
            page_reg <= 4'h0;
        else if (TABLE_POINTER_ENABLE)
            page_reg <= TABLE_PAGE_BITS; // see RL16 see RL17
    end

    // Sticky interrupt status, write one to clear, set wins
    assign event_set = {USB_BUS_RESET, ENDPOINT_ACCESS};
    always_comb
    begin
        irq_stat_next = irq_stat_reg;
        if (wr_hit(`UBC_IDX_IRQ_STATUS))
            irq_stat_next = irq_stat_reg & ~wr_byte[3:0];
        irq_stat_next = irq_stat_next | event_set; // see RL6 see RL18
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
        begin
            irq_stat_reg <= 4'h0;
            irq_mask_reg <= 4'h0;
        end
        else
        begin
            irq_stat_reg <= irq_stat_next;
            if (wr_hit(`UBC_IDX_IRQ_MASK))
                irq_mask_reg <= wr_byte[3:0];
        end
    end

    // Read data mux; write-only drive bits read as zero
    always_comb
    begin
        rd_byte = 8'h00;
        rd_ok = 1'b1;
        case (S_AXI_ARADDR)
            reg_addr(`UBC_IDX_BUS_STATUS_CONTROL):
            begin
                rd_byte[`UBC_BSC_BUS_RESET] = bus_reset_reg;
                rd_byte[`UBC_BSC_DATA_IN] = data_sync_reg[1]; // see RL1
                rd_byte[`UBC_BSC_CLOCK_IN] = clock_sync_reg[1]; // see RL2
            end
            reg_addr(`UBC_IDX_ENDPOINT_REQUEST_STATUS):
                rd_byte = {usb_ind_reg, 1'b0, usb_sel_reg, legacy_sel_reg, 1'b0, ep_flag_reg};
            reg_addr(`UBC_IDX_SYSTEM_CLOCK_CONTROL):
                rd_byte = scc_reg;
            reg_addr(`UBC_IDX_TABLE_HIGH_POINTER):
                rd_byte = {4'h0, page_reg}; // see RL16
            reg_addr(`UBC_IDX_IRQ_STATUS):
                rd_byte = {4'h0, irq_stat_reg};
            reg_addr(`UBC_IDX_IRQ_MASK):
                rd_byte = {4'h0, irq_mask_reg};
            default:
                rd_ok = 1'b0;
        endcase
    end

    // Read channel: one outstanding read, answer one cycle after address
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
        begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= 2'h0;
        end
        else
        begin
            S_AXI_ARREADY <= !S_AXI_RVALID && !(S_AXI_ARVALID && S_AXI_ARREADY);
            if (S_AXI_ARVALID && S_AXI_ARREADY)
            begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA <= {24'h00_0000, rd_byte};
                S_AXI_RRESP <= rd_ok ? ubc_pkg::UBC_RESP_OKAY : ubc_pkg::UBC_RESP_SLVERR;
            end
            else if (S_AXI_RREADY)
            begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    // Registered outputs; pins only driven in legacy mode
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
        begin
            LEGACY_DATA_OUT <= 1'b1;
            LEGACY_CLOCK_OUT <= 1'b1;
            LEGACY_DATA_OE <= 1'b0;
            LEGACY_CLOCK_OE <= 1'b0;
            USB_CLOCK_GATE <= 1'b0;
            DEEP_SUSPEND_POWER_CUT <= 1'b0;
            OSCILLATOR_FREQUENCY_SELECT <= 1'b0;
            LEGACY_FUNCTION_SELECT <= 1'b0;
            USB_FUNCTION_SELECT <= 1'b0;
            IRQ <= 1'b0;
        end
        else
        begin
            LEGACY_DATA_OUT <= drive_reg[0]; // see RL3
            LEGACY_CLOCK_OUT <= drive_reg[1]; // see RL4
            LEGACY_DATA_OE <= legacy_sel_reg; // see RL8
            LEGACY_CLOCK_OE <= legacy_sel_reg;
            USB_CLOCK_GATE <= scc_reg[`UBC_SCC_USB_CLK]; // see RL13
            DEEP_SUSPEND_POWER_CUT <= scc_reg[`UBC_SCC_DEEP_SUSP];
            OSCILLATOR_FREQUENCY_SELECT <= scc_reg[`UBC_SCC_OSC_SEL]; // see RL15
            LEGACY_FUNCTION_SELECT <= legacy_sel_reg;
            USB_FUNCTION_SELECT <= usb_sel_reg; // see RL9
            // Stack-full holds back the request without losing the status
            IRQ <= |(irq_stat_next & irq_mask_reg) && !STACK_FULL; // see RL6
        end
    end

    // Checks
    AST_FLAG_SET: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // see RL5
        ENDPOINT_ACCESS[0] |=> ep_flag_reg[0]) else $error("Endpoint flag not set");
    AST_FLAG_STICKY: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // see RL7
        ep_flag_reg[1] && !wr_hit(`UBC_IDX_ENDPOINT_REQUEST_STATUS) |=> ep_flag_reg[1])
        else $error("Endpoint flag dropped");
    AST_SET_WINS: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // see RL19
        wr_hit(`UBC_IDX_ENDPOINT_REQUEST_STATUS) && !wr_byte[2] && ENDPOINT_ACCESS[2] |=> ep_flag_reg[2])
        else $error("Clear beat set");
    AST_IRQ: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // see RL6
        ENDPOINT_ACCESS[0] && irq_mask_reg[0] && !STACK_FULL |=> IRQ) else $error("No interrupt");
    AST_IRQ_STACK: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // see RL6
        STACK_FULL |=> !IRQ) else $error("Interrupt with full stack");
    AST_BUS_RESET: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // see RL18
        USB_BUS_RESET |=> bus_reset_reg && irq_stat_reg[`UBC_IRQ_BUS_RESET]) else $error("Bus reset lost");
    AST_DATA_PIN: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // see RL3
        wr_hit(`UBC_IDX_BUS_STATUS_CONTROL) |=> ##1 LEGACY_DATA_OUT == $past(wr_byte[`UBC_BSC_DATA_OUT], 2))
        else $error("Data drive wrong");
    AST_CLOCK_PIN: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // see RL4
        wr_hit(`UBC_IDX_BUS_STATUS_CONTROL) |=> ##1 LEGACY_CLOCK_OUT == $past(wr_byte[`UBC_BSC_CLOCK_OUT], 2))
        else $error("Clock drive wrong");
    AST_SCC_ZERO: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // see RL12
        scc_reg[2:0] == 3'h0 && !scc_reg[7]) else $error("Undefined clock bits set");
    AST_USB_CLK: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // see RL13
        wr_hit(`UBC_IDX_SYSTEM_CLOCK_CONTROL) |=> ##1 USB_CLOCK_GATE == $past(wr_byte[3], 2))
        else $error("Clock gate wrong");
    AST_PAGE_OFF: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // see RL17
        !TABLE_POINTER_ENABLE |-> page_reg == 4'h0) else $error("Pointer active while disabled");
    COV_FLAG_CLEAR: cover property (@(posedge CORE_CLK) ep_flag_reg[0] ##1 !ep_flag_reg[0]);
    COV_IRQ: cover property (@(posedge CORE_CLK) !IRQ ##1 IRQ);
    COV_LEGACY: cover property (@(posedge CORE_CLK) LEGACY_DATA_OE && !LEGACY_DATA_OUT);
endmodule : ubc_regs

/* File: bench/ubc_host_model.sv */
// Far-side model: legacy host on the shared data and clock pins, with pull-ups
`timescale 1ns/1ns
module ubc_host_model (
    input wire logic frame_en,
    input wire logic host_data,
    input wire logic dev_data,
    input wire logic dev_data_oe,
    input wire logic dev_clk,
    input wire logic dev_clk_oe,
    output logic pin_data,
    output logic pin_clk
);
    logic link_clk;
    // Link clock runs only within frames and parks high between them
    initial
    begin
        link_clk = 1'b1;
        forever
        begin
            #62;
            link_clk = frame_en ? ~link_clk : 1'b1;
            #63;
            link_clk = frame_en ? ~link_clk : 1'b1;
        end
    end
    // Open-drain wires: either party pulls low, the pull-up wins otherwise
    assign pin_data = !((dev_data_oe && !dev_data) || (frame_en && !host_data));
    assign pin_clk = !((dev_clk_oe && !dev_clk) || (frame_en && !link_clk));
endmodule : ubc_host_model

/* File: bench/ubc_regs_test.sv */
// Self-checking bench for the bus control register bank
`timescale 1ns/1ns
module ubc_regs_test;
    logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, bus_rst, stack_full, frame_en, host_data, br_m;
    logic awready, wready, bvalid, arready, rvalid, dout, doe, cout, coe, pin_d, pin_c;
    logic usb_gate, deep, osc, lsel, usel, irq;
    logic [7:0] awaddr, araddr, ep_m, irq_m, d;
    logic [31:0] wdata, rdata;
    logic [3:0] page, wstrb;
    logic [2:0] ep_acc;
    logic [1:0] bresp, rresp;
    int n_mismatch, n_tests;

    ubc_regs #(.TABLE_POINTER_ENABLE(1'b1)) u_ubc_regs (.CORE_CLK(clk), .RST_N(rst_n),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .LEGACY_DATA_IN(pin_d), .LEGACY_CLOCK_IN(pin_c), .LEGACY_DATA_OUT(dout),
        .LEGACY_DATA_OE(doe), .LEGACY_CLOCK_OUT(cout), .LEGACY_CLOCK_OE(coe), .ENDPOINT_ACCESS(ep_acc),
        .USB_BUS_RESET(bus_rst), .STACK_FULL(stack_full), .TABLE_PAGE_BITS(page), .USB_CLOCK_GATE(usb_gate),
        .DEEP_SUSPEND_POWER_CUT(deep), .OSCILLATOR_FREQUENCY_SELECT(osc), .LEGACY_FUNCTION_SELECT(lsel),
        .USB_FUNCTION_SELECT(usel), .IRQ(irq));

    ubc_host_model u_ubc_host_model (.frame_en(frame_en), .host_data(host_data), .dev_data(dout),
        .dev_data_oe(doe), .dev_clk(cout), .dev_clk_oe(coe), .pin_data(pin_d), .pin_clk(pin_c));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task final_report;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : final_report

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Expected bus status: live pins, bus reset flag, drive bits read as 0
    function automatic logic [7:0] bsc_exp();
        return {2'h0, pin_c, pin_d, 1'b0, br_m, 2'h0};
    endfunction : bsc_exp

    // Write: address and data offered together, each dropped once taken
    task automatic axw(input logic [7:0] a, input logic [7:0] v, input logic [1:0] er);
        int k;
        logic ad, dd;
        ad = 1'b0;
        dd = 1'b0;
        awaddr <= a;
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (k = 0; k < 40; k++)
        begin
            @(posedge clk);
            ad = ad | awready;
            dd = dd | wready;
            awvalid <= !ad;
            wvalid <= !dd;
            if (bvalid)
                break;
        end
        bready <= 1'b0;
        if (k == 40)
        begin
            n_mismatch++;
            final_report();
        end
        chk({30'h0, bresp}, {30'h0, er});
        // Extra edge so the next request never lands in the same time step
        @(posedge clk);
    endtask : axw

    // Read: only bits under mask m are compared
    task automatic axr(input logic [7:0] a, input logic [7:0] ev, input logic [7:0] m, input logic [1:0] er);
        int k;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (k = 0; k < 40; k++)
        begin
            @(posedge clk);
            if (arready)
                arvalid <= 1'b0;
            if (rvalid)
                break;
        end
        rready <= 1'b0;
        if (k == 40)
        begin
            n_mismatch++;
            final_report();
        end
        chk(rdata & {24'h0, m}, {24'h0, ev & m});
        chk({30'h0, rresp}, {30'h0, er});
        @(posedge clk);
    endtask : axr

    // Main sequence acting as firmware
    initial
    begin
        rst_n = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, bus_rst, stack_full, frame_en, br_m} = 9'h000;
        {awaddr, araddr, wdata, page, ep_acc, ep_m, irq_m} = 71'h0;
        host_data = 1'b1;
        wstrb = 4'hF;
        n_mismatch = 0;
        n_tests = 0;
        d = 8'($urandom(23583));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk({28'h0, dout, cout, doe, coe}, 32'hC);
        axr(8'h68, bsc_exp(), 8'hFF, 2'h0);
        axr(8'h6C, 8'h00, 8'hFF, 2'h0);
        axr(8'h70, 8'h00, 8'hFF, 2'h0);
        axr(8'h40, 8'h00, 8'hFF, 2'h2);
        axw(8'h40, 8'hFF, 2'h2);
        // Undefined clock bits kept 0; deep suspend toggled as if entering halt
        repeat (4)
        begin
            d = 8'($urandom) & 8'h78;
            axw(8'h70, d, 2'h0);
            axr(8'h70, d, 8'hFF, 2'h0);
            chk({29'h0, usb_gate, deep, osc}, {29'h0, d[3], d[4], d[6]});
        end
        // Byte lane 0 off: the write is accepted but must leave the register alone
        wstrb <= 4'hE;
        axw(8'h70, 8'h08 ^ d, 2'h0);
        wstrb <= 4'hF;
        axr(8'h70, d, 8'hFF, 2'h0);
        // Endpoint events: plain, stack full, masked
        for (int i = 0; i < 3; i++)
        begin
            axw(8'h84, (i == 2) ? 8'h00 : 8'h0F, 2'h0);
            stack_full <= (i == 1);
            ep_acc <= 3'(1 << i);
            @(posedge clk);
            ep_acc <= 3'h0;
            repeat (2) @(posedge clk);
            ep_m[i] = 1'b1;
            irq_m[i] = 1'b1;
            chk({31'h0, irq}, {31'h0, i == 0});
            axr(8'h6C, ep_m, 8'hFF, 2'h0);
            axw(8'h6C, 8'h07 ^ 8'(1 << i), 2'h0);
            ep_m[i] = 1'b0;
            axr(8'h6C, ep_m, 8'hFF, 2'h0);
            axw(8'h80, 8'(1 << i), 2'h0);
            irq_m[i] = 1'b0;
            axr(8'h80, irq_m, 8'hFF, 2'h0);
            chk({31'h0, irq}, 32'h0);
        end
        // Engine keeps setting flag 2 while firmware clears it: the set must win
        ep_acc <= 3'h4;
        axw(8'h6C, 8'h03, 2'h0);
        ep_acc <= 3'h0;
        axr(8'h6C, 8'h04, 8'hFF, 2'h0);
        axw(8'h6C, 8'h03, 2'h0);
        axr(8'h6C, 8'h00, 8'hFF, 2'h0);
        axw(8'h80, 8'h04, 2'h0);
        axr(8'h80, 8'h00, 8'hFF, 2'h0);
        stack_full <= 1'b0;
        axw(8'h84, 8'h0F, 2'h0);
        bus_rst <= 1'b1;
        @(posedge clk);
        bus_rst <= 1'b0;
        repeat (2) @(posedge clk);
        br_m = 1'b1;
        chk({31'h0, irq}, 32'h1);
        axr(8'h68, bsc_exp(), 8'hFF, 2'h0);
        axr(8'h80, 8'h08, 8'hFF, 2'h0);
        axw(8'h80, 8'h08, 2'h0);
        // Legacy function drives the pins from the bus status bits
        axw(8'h6C, 8'h10, 2'h0);
        chk({29'h0, lsel, doe, coe}, 32'h7);
        axw(8'h68, 8'h04, 2'h0);
        repeat (4) @(posedge clk);
        chk({30'h0, dout, cout}, 32'h0);
        axr(8'h68, bsc_exp(), 8'hFF, 2'h0);
        axw(8'h68, 8'h40, 2'h0);
        br_m = 1'b0;
        repeat (4) @(posedge clk);
        axr(8'h68, bsc_exp(), 8'hFF, 2'h0);
        axw(8'h6C, 8'hA0, 2'h0);
        chk({28'h0, lsel, usel, doe, coe}, 32'h4);
        axr(8'h6C, 8'hA0, 8'hFF, 2'h0);
        // Host frame: data held low while the link clock runs
        frame_en <= 1'b1;
        host_data <= 1'b0;
        repeat (20) @(posedge clk);
        axr(8'h68, 8'h00, 8'h10, 2'h0);
        frame_en <= 1'b0;
        host_data <= 1'b1;
        repeat (30) @(posedge clk);
        axr(8'h68, 8'h30, 8'hFF, 2'h0);
        repeat (3)
        begin
            page <= 4'($urandom);
            repeat (3) @(posedge clk);
            axr(8'h7C, {4'h0, page}, 8'hFF, 2'h0);
        end
        final_report();
    end
endmodule : ubc_regs_test
